//--- inc/emb_pkg.sv
// Constants, register map and timing counts of the external bus sequencer.
// Assumes one system clock; counts are in system clocks, except the stretch table, which counts stretch cycles.
// Function
// (R01) External code fetch takes 4 clocks, internal fetch takes 1 clock.
// (R02) Latch strobe idle on internal fetches unless option bit enables it.
// (R03) Address latch strobe always pulses on non-page external code fetches.
// (R04) Program store strobe asserted only during external code fetches.
// (R05) External data cycle is four clocks, internal data cycle one clock.
// (R06) Stretch is clock control bits 2:0; software may change it anytime.
// (R07) Every stretch machine cycle is four system clocks.
// (R08) Stretch codes 0..7 add 0,1,2,3,7,8,9,10 stretch cycles.
// (R09) Stretch zero gives an unstretched data access.
// (R10) Stretch 1,2,3 lengthen the data access by 1,2,3 stretch cycles.
// (R11) First stretch adds a setup clock and a hold clock, not strobe width; the code also widens the strobe by two clocks.
// (R12) Stretch 4..7 add four clocks to latch strobe, setup, hold and strobe.
// (R13) Stretch field resets to 1.
// (R14) Page enable bit 7 of access control selects page mode, else non-page.
// (R15) Page select 00,01,10 give 1/2, 2/4, 4/8 clocks per hit/miss.
// (R16) Page select 00..10: port zero data, port two multiplexed address.
// (R17) Select 11: port zero low address, port two high address then data.
// (R18) Select 11 speeds code fetches only; data uses non-page timing.
// (R19) Access control writes accepted only after a timed-access sequence.
// (R20) Page hit when upper address byte equals previous external access.
// (R21) No address latch strobe on page-hit cycles.
// (R22) Stretch and page settings are sampled at the start of each access.
package emb_pkg;
  localparam logic [7:0] ADDR_CLOCK_CONTROL  = 8'h8E;
  localparam logic [7:0] ADDR_BUS_OPTION     = 8'h8F;
  localparam logic [7:0] ADDR_ACCESS_CONTROL = 8'h9D;
  localparam logic [7:0] ADDR_TIMED_ACCESS   = 8'hC7;
  localparam logic [7:0] ADDR_BUS_STATUS     = 8'hC8;

  localparam logic [7:0] CLOCK_CONTROL_RESET  = 8'h01;
  localparam logic [7:0] ACCESS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ACCESS_CONTROL_MASK  = 8'hE0;
  localparam int         PAGE_ENABLE_BIT      = 7;
  localparam int         PAGE_SELECT_LSB      = 5;
  localparam int         ALE_INTERNAL_BIT     = 0;

  localparam logic [7:0] TA_KEY_FIRST  = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [2:0] TA_WINDOW     = 3'h4;

  localparam logic [1:0] PAGE_SEL_ONE  = 2'h0;
  localparam logic [1:0] PAGE_SEL_TWO  = 2'h1;
  localparam logic [1:0] PAGE_SEL_FOUR = 2'h2;
  localparam logic [1:0] PAGE_SEL_ALT  = 2'h3;

  // Page hit lengths; a miss is twice the hit length
  localparam logic [5:0] HIT_CLK_SEL0 = 6'h01;
  localparam logic [5:0] HIT_CLK_SEL1 = 6'h02;
  localparam logic [5:0] HIT_CLK_SEL2 = 6'h04;
  localparam logic [5:0] HIT_CLK_SEL3 = 6'h02;

  localparam logic [5:0] NP_CYCLE_CLK   = 6'h04;
  localparam logic [5:0] NP_CODE_ALE    = 6'h01;
  localparam logic [5:0] NP_CODE_STRB   = 6'h02;
  localparam logic [5:0] DATA_ALE_SHORT = 6'h01;
  localparam logic [5:0] DATA_ALE_LONG  = 6'h05;
  localparam logic [5:0] SETUP_S0       = 6'h01;
  localparam logic [5:0] SETUP_SHORT    = 6'h02;
  localparam logic [5:0] SETUP_LONG     = 6'h06;
  localparam logic [5:0] STRB_S0        = 6'h02;
  localparam int         STRETCH_SHIFT  = 2;
  // Added stretch cycles per code, four bits each, code 0 lowest
  localparam logic [31:0] STRETCH_TABLE = 32'hA9873210;
endpackage : emb_pkg

//--- inc/emb_tim_if.sv
// Interface between the sequencer and its cycle timing calculator.
// Assumes a purely combinational calculator.
`timescale 1ns/1ps
`default_nettype none
interface emb_tim_if;
  logic       page_en;
  logic [1:0] page_sel;
  logic [2:0] stretch;
  logic       is_code;
  logic       hit;
  logic [5:0] total;
  logic [5:0] ale_end;
  logic [5:0] strb_start;
  logic [5:0] strb_end;
  modport calc (input page_en, page_sel, stretch, is_code, hit,
                output total, ale_end, strb_start, strb_end);
  modport user (output page_en, page_sel, stretch, is_code, hit,
                input total, ale_end, strb_start, strb_end);
endinterface : emb_tim_if
`default_nettype wire

//--- verilog/emb_timing.sv
// Cycle timing calculator: length and strobe windows of one external access.
// Assumes inputs are held stable for the cycle in which they are used.
`timescale 1ns/1ps
`default_nettype none
module emb_timing (
  emb_tim_if.calc t
);
  import emb_pkg::*;
  logic [3:0] added;
  logic [5:0] hit_len;
  logic [5:0] stretch_clk;

  always_comb begin
    added       = STRETCH_TABLE[{t.stretch, 2'h0} +: 4];              // [R08]
    stretch_clk = {added, 2'h0};                                      // [R07]
    case (t.page_sel)                                                 // [R15]
      PAGE_SEL_ONE:  hit_len = HIT_CLK_SEL0;
      PAGE_SEL_TWO:  hit_len = HIT_CLK_SEL1;
      PAGE_SEL_FOUR: hit_len = HIT_CLK_SEL2;
      default:       hit_len = HIT_CLK_SEL3;
    endcase
    if (!t.page_en                                                    // [R14]
        || (t.page_sel == PAGE_SEL_ALT && !t.is_code)) begin          // [R18]
      if (t.is_code) begin
        t.total      = NP_CYCLE_CLK;                                  // [R01]
        t.ale_end    = NP_CODE_ALE;                                   // [R03]
        t.strb_start = NP_CODE_STRB;
        t.strb_end   = NP_CYCLE_CLK;
      end else begin
        t.total = 6'(NP_CYCLE_CLK + stretch_clk); // [R05] [R10]
        if (t.stretch == 3'h0) begin                                  // [R09]
          t.ale_end  = DATA_ALE_SHORT;
          t.strb_start = 6'(DATA_ALE_SHORT + SETUP_S0);
          t.strb_end = 6'(DATA_ALE_SHORT + SETUP_S0 + STRB_S0);
        end else if (!t.stretch[2]) begin                             // [R11]
          t.ale_end  = DATA_ALE_SHORT;
          t.strb_start = 6'(DATA_ALE_SHORT + SETUP_SHORT);
          t.strb_end = 6'(DATA_ALE_SHORT + SETUP_SHORT
                          + {1'b0, t.stretch, 2'h0});
        end else begin                                                // [R12]
          t.ale_end  = DATA_ALE_LONG;
          t.strb_start = 6'(DATA_ALE_LONG + SETUP_LONG);
          t.strb_end = 6'(DATA_ALE_LONG + SETUP_LONG
                          + {1'b0, t.stretch, 2'h0});
        end
      end
    end else begin
      if (t.hit) begin                                                // [R21]
        t.ale_end    = 6'h00;
        t.strb_start = 6'h00;
        t.strb_end   = hit_len;
        t.total      = hit_len;
      end else begin
        t.ale_end    = hit_len;
        t.strb_start = hit_len;
        t.strb_end   = 6'(hit_len + hit_len);
        t.total      = 6'(hit_len + hit_len);
      end
      if (!t.is_code) begin
        t.total    = 6'(t.total + stretch_clk);
        t.strb_end = 6'(t.strb_end + stretch_clk);
      end
    end
  end
endmodule : emb_timing
`default_nettype wire

//--- verilog/emb_seq.sv
// External program and data memory bus sequencer with its control registers.
// Assumes requests come from the core, pins are synchronous to clk_in.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module emb_seq (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [7:0]  reg_rdata_out,
  // Core access request
  input  wire logic        req_in,
  input  wire logic        req_code_in,
  input  wire logic        req_write_in,
  input  wire logic        req_internal_in,
  input  wire logic [15:0] req_addr_in,
  input  wire logic [7:0]  req_wdata_in,
  output logic             req_ready_out,
  output logic             done_out,
  output logic      [7:0]  rdata_out,
  // External bus pins
  output logic             addr_latch_out,
  output logic             program_store_strobe_n_out,
  output logic             rd_n_out,
  output logic             wr_n_out,
  input  wire logic [7:0]  port_zero_in,
  output logic      [7:0]  port_zero_out,
  output logic             port_zero_oe_out,
  input  wire logic [7:0]  port_two_in,
  output logic      [7:0]  port_two_out,
  output logic             port_two_oe_out
);
  import emb_pkg::*;

  typedef enum logic [2:0] {
    EMB_IDLE = 3'b001,
    EMB_INT  = 3'b010,
    EMB_EXT  = 3'b100
  } emb_state_e;

  emb_state_e state_reg;
  emb_state_e state_next;
  logic [7:0]  clock_control_reg;
  logic [7:0]  access_control_reg;
  logic [7:0]  bus_option_reg;
  logic        ta_stage_reg;
  logic [2:0]  ta_window_reg;
  logic [7:0]  last_hi_reg;
  logic        last_valid_reg;
  logic        last_hit_reg;
  logic [5:0]  cnt_reg;
  logic [5:0]  total_reg;
  logic [5:0]  ale_end_reg;
  logic [5:0]  strb_start_reg;
  logic [5:0]  strb_end_reg;
  logic        code_reg;
  logic        write_reg;
  logic        page_en_reg;
  logic [1:0]  page_sel_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic        accept;
  logic        hit;
  logic        last_cycle;
  logic        run;
  logic [5:0]  c_next;
  logic [5:0]  w_ale;
  logic [5:0]  w_ss;
  logic [5:0]  w_se;
  logic        w_code;
  logic        w_write;
  logic        w_alt;
  logic        w_page;
  logic [15:0] w_addr;
  logic [7:0]  w_wdata;
  logic        ph_ale;
  logic        ph_strb;

  emb_tim_if tim ();
  emb_timing u_timing (
    .t (tim.calc)
  );

  assign accept     = req_in && (state_reg == EMB_IDLE);
  assign hit        = last_valid_reg && (last_hi_reg == req_addr_in[15:8]); // [R20]
  assign last_cycle = (state_reg == EMB_EXT) && (cnt_reg == 6'(total_reg - 6'h01));
  assign req_ready_out = (state_reg == EMB_IDLE);
  assign done_out      = (state_reg == EMB_INT) || last_cycle;       // [R01] [R05]

  // Settings sampled at the start of an access
  assign tim.page_en  = access_control_reg[PAGE_ENABLE_BIT];          // [R22]
  assign tim.page_sel = access_control_reg[PAGE_SELECT_LSB +: 2];
  assign tim.stretch  = clock_control_reg[2:0];                       // [R06]
  assign tim.is_code  = req_code_in;
  assign tim.hit      = hit;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EMB_IDLE: begin
        if (req_in) begin
          state_next = req_internal_in ? EMB_INT : EMB_EXT;
        end
      end
      EMB_INT:  state_next = EMB_IDLE;                                // [R01]
      EMB_EXT: begin
        if (last_cycle) begin
          state_next = EMB_IDLE;
        end
      end
      default:  state_next = EMB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= EMB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Access parameters, latched once per external access
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      total_reg      <= 6'h00;
      ale_end_reg    <= 6'h00;
      strb_start_reg <= 6'h00;
      strb_end_reg   <= 6'h00;
      code_reg       <= 1'b0;
      write_reg      <= 1'b0;
      page_en_reg    <= 1'b0;
      page_sel_reg   <= 2'h0;
      addr_reg       <= 16'h0000;
      wdata_reg      <= 8'h00;
      last_hit_reg   <= 1'b0;
    end else if (accept && !req_internal_in) begin                   // [R22]
      total_reg      <= tim.total;
      ale_end_reg    <= tim.ale_end;
      strb_start_reg <= tim.strb_start;
      strb_end_reg   <= tim.strb_end;
      code_reg       <= req_code_in;
      write_reg      <= req_write_in;
      page_en_reg    <= tim.page_en;
      page_sel_reg   <= tim.page_sel;
      addr_reg       <= req_addr_in;
      wdata_reg      <= req_wdata_in;
      last_hit_reg   <= hit && tim.page_en
                        && !(tim.page_sel == PAGE_SEL_ALT && !req_code_in);
    end
  end

  // Page tracking of the upper address byte
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      last_hi_reg    <= 8'h00;
      last_valid_reg <= 1'b0;
    end else if (accept && !req_internal_in) begin                   // [R20]
      last_hi_reg    <= req_addr_in[15:8];
      last_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_reg <= 6'h00;
    end else if (accept) begin
      cnt_reg <= 6'h00;
    end else if (state_reg == EMB_EXT && !last_cycle) begin
      cnt_reg <= 6'(cnt_reg + 6'h01);
    end
  end

  // Phase of the next cycle, taken from the calculator on the start edge
  always_comb begin
    run     = (accept && !req_internal_in)
              || (state_reg == EMB_EXT && !last_cycle);
    c_next  = accept ? 6'h00 : 6'(cnt_reg + 6'h01);
    w_ale   = accept ? tim.ale_end : ale_end_reg;
    w_ss    = accept ? tim.strb_start : strb_start_reg;
    w_se    = accept ? tim.strb_end : strb_end_reg;
    w_code  = accept ? req_code_in : code_reg;
    w_write = accept ? req_write_in : write_reg;
    w_page  = accept ? tim.page_en : page_en_reg;
    w_alt   = (accept ? tim.page_sel : page_sel_reg) == PAGE_SEL_ALT;
    w_addr  = accept ? req_addr_in : addr_reg;
    w_wdata = accept ? req_wdata_in : wdata_reg;
    ph_ale  = run && (c_next < w_ale);
    ph_strb = run && (c_next >= w_ss) && (c_next < w_se);
  end

  // Control strobes
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      addr_latch_out             <= 1'b0;
      program_store_strobe_n_out <= 1'b1;
      rd_n_out                   <= 1'b1;
      wr_n_out                   <= 1'b1;
    end else begin
      addr_latch_out <= ph_ale                                        // [R03] [R21]
                        || (accept && req_internal_in && req_code_in
                            && bus_option_reg[ALE_INTERNAL_BIT]);     // [R02]
      program_store_strobe_n_out <= !(ph_strb && w_code);             // [R04]
      rd_n_out <= !(ph_strb && !w_code && !w_write);
      wr_n_out <= !(ph_strb && !w_code && w_write);
    end
  end

  // Address and data ports
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      port_zero_out    <= 8'h00;
      port_zero_oe_out <= 1'b0;
      port_two_out     <= 8'h00;
      port_two_oe_out  <= 1'b0;
    end else if (!run) begin
      port_zero_oe_out <= 1'b0;
      port_two_oe_out  <= 1'b0;
    end else if (w_page && w_alt) begin                               // [R17]
      port_zero_out    <= w_addr[7:0];
      port_zero_oe_out <= 1'b1;
      port_two_out     <= (ph_ale || c_next < w_ss || w_write)
                          && !(c_next >= w_ss && w_write)
                          ? w_addr[15:8] : w_wdata;
      port_two_oe_out  <= ph_ale || c_next < w_ss || (w_write && !w_code);
    end else if (w_page) begin                                        // [R16]
      port_two_out     <= ph_ale ? w_addr[15:8] : w_addr[7:0];
      port_two_oe_out  <= 1'b1;
      port_zero_out    <= w_wdata;
      port_zero_oe_out <= !ph_ale && w_write && !w_code;
    end else begin                                                    // [R14]
      port_two_out     <= w_addr[15:8];
      port_two_oe_out  <= 1'b1;
      port_zero_out    <= ph_ale ? w_addr[7:0] : w_wdata;
      port_zero_oe_out <= ph_ale || (w_write && !w_code
                                     && c_next >= w_ss);
    end
  end

  // Read data captured in the last strobe cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (state_reg == EMB_EXT && !write_reg
                 && cnt_reg == 6'(strb_end_reg - 6'h01)) begin
      rdata_out <= (page_en_reg && page_sel_reg == PAGE_SEL_ALT)
                   ? port_two_in : port_zero_in;
    end
  end

  // Register writes
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      clock_control_reg <= CLOCK_CONTROL_RESET;                       // [R13]
      bus_option_reg    <= 8'h00;
    end else if (reg_write_in) begin
      if (reg_addr_in == ADDR_CLOCK_CONTROL) begin
        clock_control_reg <= reg_wdata_in;                            // [R06]
      end
      if (reg_addr_in == ADDR_BUS_OPTION) begin
        bus_option_reg <= reg_wdata_in;
      end
    end
  end

  // Timed-access unlock: first key, then second key, then a short window
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ta_stage_reg  <= 1'b0;
      ta_window_reg <= 3'h0;
    end else begin
      if (reg_write_in && reg_addr_in == ADDR_TIMED_ACCESS) begin
        ta_stage_reg <= (reg_wdata_in == TA_KEY_FIRST);
      end else if (reg_write_in) begin
        ta_stage_reg <= 1'b0;
      end
      if (reg_write_in && reg_addr_in == ADDR_TIMED_ACCESS
          && ta_stage_reg && reg_wdata_in == TA_KEY_SECOND) begin     // [R19]
        ta_window_reg <= TA_WINDOW;
      end else if (reg_write_in && reg_addr_in == ADDR_ACCESS_CONTROL) begin
        ta_window_reg <= 3'h0;
      end else if (ta_window_reg != 3'h0) begin
        ta_window_reg <= 3'(ta_window_reg - 3'h1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      access_control_reg <= ACCESS_CONTROL_RESET;
    end else if (reg_write_in && reg_addr_in == ADDR_ACCESS_CONTROL
                 && ta_window_reg != 3'h0) begin                      // [R19]
      access_control_reg <= reg_wdata_in & ACCESS_CONTROL_MASK;
    end
  end

  // Register reads, data in the following cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_CLOCK_CONTROL:  reg_rdata_out <= clock_control_reg;
        ADDR_BUS_OPTION:     reg_rdata_out <= bus_option_reg;
        ADDR_ACCESS_CONTROL: reg_rdata_out <= access_control_reg;
        ADDR_BUS_STATUS:     reg_rdata_out <= {5'h00, ta_window_reg != 3'h0,
                                               last_hit_reg,
                                               state_reg != EMB_IDLE};
        default:             reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Checks
  a_int_fetch_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && req_internal_in |=> done_out && $rose(req_ready_out) == 1'b0) // [R01]
    else $error("internal access not one clock");

  a_np_code_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !req_internal_in && req_code_in
      && !access_control_reg[PAGE_ENABLE_BIT]
    |=> !done_out [*3] ##1 done_out) // [R01]
    else $error("non-page code fetch not four clocks");

  a_np_code_ale: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !req_internal_in && req_code_in
      && !access_control_reg[PAGE_ENABLE_BIT]
    |=> addr_latch_out ##1 !addr_latch_out) // [R03]
    else $error("latch strobe missing on external fetch");

  a_pstrb_internal: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_reg == EMB_INT || (state_reg == EMB_EXT && !code_reg)
    |-> program_store_strobe_n_out) // [R04]
    else $error("program strobe active outside external fetch");

  a_ale_internal: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_reg == EMB_INT && !$past(bus_option_reg[ALE_INTERNAL_BIT])
    |-> !addr_latch_out) // [R02]
    else $error("latch strobe on internal fetch");

  a_stretch_one_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !req_internal_in && !req_code_in
      && !access_control_reg[PAGE_ENABLE_BIT]
      && clock_control_reg[2:0] == 3'h1
    |=> !done_out [*7] ##1 done_out) // [R10]
    else $error("stretch one data access not eight clocks");

  a_stretch_four_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    accept && !req_internal_in && !req_code_in
      && !access_control_reg[PAGE_ENABLE_BIT]
      && clock_control_reg[2:0] == 3'h4
    |=> ##31 done_out) // [R08]
    else $error("stretch four data access not thirty-two clocks");

  a_page_hit_ale: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_reg == EMB_EXT && last_hit_reg |-> !addr_latch_out) // [R21]
    else $error("latch strobe during page hit");

  a_actl_locked: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_write_in && reg_addr_in == ADDR_ACCESS_CONTROL && ta_window_reg == 3'h0
    |=> $stable(access_control_reg)) // [R19]
    else $error("access control written without unlock");

  a_stretch_reset: assert property (@(posedge clk_in)
    !resetn_in |=> clock_control_reg[2:0] == 3'h1) // [R13]
    else $error("stretch field not one after reset");

endmodule : emb_seq
`default_nettype wire

//--- tb/emb_mem_model.sv
// External memory answering fetch and read strobes with a fixed byte.
// Assumes the sequencer's pins are synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model #(
  parameter logic [7:0] READ_BYTE = 8'h5A
) (
  // Clock
  input  wire logic       clk_in,
  // Strobes
  input  wire logic       pstrb_n_in,
  input  wire logic       rd_n_in,
  // Ports as driven by the sequencer
  input  wire logic [7:0] pz_in,
  input  wire logic       pz_oe_in,
  input  wire logic [7:0] pt_in,
  input  wire logic       pt_oe_in,
  // Resolved port levels
  output logic      [7:0] pz_out,
  output logic      [7:0] pt_out
);
  logic [7:0] idle_reg = 8'hC3;
  logic [7:0] mem_drv;
  // Released bus shows a changing pattern, never the last value
  always_ff @(posedge clk_in) begin
    idle_reg <= ~idle_reg;
  end
  assign mem_drv = (!pstrb_n_in || !rd_n_in) ? READ_BYTE : idle_reg;
  assign pz_out  = pz_oe_in ? pz_in : mem_drv;
  assign pt_out  = pt_oe_in ? pt_in : mem_drv;
endmodule : emb_mem_model
`default_nettype wire

//--- tb/external_memory_bus_timing_tb.sv
// Self-checking bench for the external bus sequencer.
// Assumes the memory model answers every read or fetch strobe.
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_timing_tb;
  import emb_pkg::*;
  localparam logic [7:0] RB = 8'h5A;
  logic        clk_in, resetn_in, reg_write_in, reg_read_in, req_in;
  logic        req_code_in, req_write_in, req_internal_in, req_ready_out;
  logic        done_out, ale, pstrb_n, rd_n, wr_n, pz_oe, pt_oe;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, req_wdata_in;
  logic [7:0]  rdata_out, pz_in, pz_out, pt_in, pt_out, rv;
  logic [15:0] req_addr_in;
  logic [3:0]  seen;
  logic [23:0] snap;
  int          fails, n_checks, cyc, ticks;
  int          st[8] = '{0, 1, 2, 3, 7, 8, 9, 10};
  emb_seq u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .req_in(req_in),
    .req_code_in(req_code_in), .req_write_in(req_write_in),
    .req_internal_in(req_internal_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .done_out(done_out), .rdata_out(rdata_out), .addr_latch_out(ale),
    .program_store_strobe_n_out(pstrb_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .port_zero_in(pz_in), .port_zero_out(pz_out),
    .port_zero_oe_out(pz_oe), .port_two_in(pt_in),
    .port_two_out(pt_out), .port_two_oe_out(pt_oe));
  emb_mem_model #(.READ_BYTE(RB)) u_mem (.clk_in(clk_in),
    .pstrb_n_in(pstrb_n), .rd_n_in(rd_n), .pz_in(pz_out), .pz_oe_in(pz_oe),
    .pt_in(pt_out), .pt_oe_in(pt_oe), .pz_out(pz_in), .pt_out(pt_in));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic chk8(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkn(input int got, exp);
    n_checks++;
    if (got != exp) begin
      fails++;
      $display("BAD %0t cycles %0d want %0d", $time, got, exp);
    end
  endtask : chkn
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    @(negedge clk_in);
    rv = reg_rdata_out;
  endtask : rd
  // One access; checks its length and which strobes were seen against n and s
  task automatic run(input logic c, w, i, input logic [15:0] a,
                     input int n, input logic [3:0] s);
    for (int k = 0; k < 64 && req_ready_out !== 1'b1; k++) @(negedge clk_in);
    @(posedge clk_in);
    req_in          <= 1'b1;
    req_code_in     <= c;
    req_write_in    <= w;
    req_internal_in <= i;
    req_addr_in     <= a;
    req_wdata_in    <= a[7:0];
    @(posedge clk_in);
    req_in <= 1'b0;
    seen = 4'h0;
    for (cyc = 1; cyc < 100; cyc++) begin
      @(negedge clk_in);
      seen = seen | {ale, ~pstrb_n, ~rd_n, ~wr_n};
      if (cyc == 1) begin
        snap = {req_ready_out, pt_oe, pz_oe, 5'h00, pt_out, pz_out};
      end
      if (done_out === 1'b1) break;
    end
    chkn(cyc, n);
    chk8({4'h0, seen}, {4'h0, s});
  endtask : run
  task automatic unlock(input logic [7:0] v);
    wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
    wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
    wr(ADDR_ACCESS_CONTROL, v);
  endtask : unlock
  task automatic t_regs();
    rd(8'h8E);
    chk8(rv, 8'h01);
    rd(8'h80);
    chk8(rv, 8'h00);
    wr(ADDR_ACCESS_CONTROL, 8'h80);
    rd(ADDR_ACCESS_CONTROL);
    chk8(rv, 8'h00);
    $display("registers done");
  endtask : t_regs
  task automatic t_fetch();
    run(1'b1, 1'b0, 1'b1, 16'h0010, 1, 4'b0000);
    wr(ADDR_BUS_OPTION, 8'h01);
    run(1'b1, 1'b0, 1'b1, 16'h0011, 1, 4'b1000);
    run(1'b1, 1'b0, 0, 16'h0234, 4, 4'b1100);
    chk8(snap[23:16], 8'h60);
    chk8(snap[15:8], 8'h02);
    chk8(snap[7:0], 8'h34);
    @(negedge clk_in);
    chk8(rdata_out, RB);
    $display("fetch done");
  endtask : t_fetch
  task automatic t_stretch();
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CLOCK_CONTROL, 8'(s));
      run(1'b0, 1'b0, 1'b0, 16'h0100, 4 + 4 * st[s], 4'b1010);
    end
    run(1'b0, 1'b1, 1'b0, 16'h0101, 44, 4'b1001);
    $display("stretch done");
  endtask : t_stretch
  task automatic t_page();
    wr(ADDR_CLOCK_CONTROL, 8'h00);
    for (int s = 0; s < 3; s++) begin
      unlock(8'h80 | 8'(s << 5));
      rd(ADDR_ACCESS_CONTROL);
      chk8(rv, 8'h80 | 8'(s << 5));
      run(1'b1, 1'b0, 1'b0, {8'(s + 64), 8'h00}, 2 << s, 4'b1100);
      chk8(snap[23:16], 8'h40);
      chk8(snap[15:8], 8'(s + 64));
      run(1'b1, 1'b0, 1'b0, {8'(s + 64), 8'h01}, 1 << s, 4'b0100);
      chk8(snap[15:8], 8'h01);
      run(1'b0, 1'b0, 1'b0, {8'(s + 64), 8'h02}, 1 << s, 4'b0010);
    end
    unlock(8'hE0);
    run(1'b1, 1'b0, 1'b0, 16'h5000, 4, 4'b1100);
    chk8(snap[15:8], 8'h50);
    chk8(snap[7:0], 8'h00);
    run(1'b1, 1'b0, 1'b0, 16'h5001, 2, 4'b0100);
    chk8(snap[23:16], 8'h20);
    chk8(snap[7:0], 8'h01);
    run(1'b0, 1'b0, 1'b0, 16'h5002, 4, 4'b1010);
    $display("page done");
  endtask : t_page
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    {resetn_in, reg_write_in, reg_read_in, req_in, req_code_in} = 5'h00;
    {req_write_in, req_internal_in, reg_addr_in, reg_wdata_in} = 18'h00000;
    {req_addr_in, req_wdata_in} = 24'h000000;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_fetch();
    t_stretch();
    t_page();
    give_verdict();
  end
endmodule : external_memory_bus_timing_tb
`default_nettype wire
